/* src/asr_consts.vh */
// register indices, field positions, reset values and timing counts of the converter sequencer
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH

// register indices; byte address is four times the index
`define ASR_IDX_SEQ_CFG 6'h34
`define ASR_IDX_CTRL 6'h35
`define ASR_IDX_RESULT_LO 6'h36
`define ASR_IDX_RESULT_HI 6'h37
`define ASR_IDX_IRQ_STATUS 6'h38
`define ASR_IDX_IRQ_MASK 6'h39

// seq_cfg fields
`define ASR_CFG_MODE_HI 7
`define ASR_CFG_MODE_LO 6
`define ASR_CFG_FIRST_HI 5
`define ASR_CFG_FIRST_LO 3
`define ASR_CFG_END_HI 2
`define ASR_CFG_END_LO 0

// ctrl fields
`define ASR_CTRL_BUSY 7
`define ASR_CTRL_DONE 6
`define ASR_CTRL_IRQ_EN 5
`define ASR_CTRL_HOLD 4
`define ASR_CTRL_TRIG_HI 3
`define ASR_CTRL_TRIG_LO 2
`define ASR_CTRL_KICK 1

// result_hi fields
`define ASR_HI_RES_SEL 7
`define ASR_HI_SMP_HI 6
`define ASR_HI_SMP_LO 5
`define ASR_HI_CMP_HI 4
`define ASR_HI_CMP_LO 3

// irq status / mask bits
`define ASR_IRQ_DONE 0
`define ASR_IRQ_SEQ_END 1
`define ASR_IRQ_HOLD 2
`define ASR_IRQ_W 3

// sequencing modes
`define ASR_MODE_SINGLE0 2'h0
`define ASR_MODE_SINGLE1 2'h1
`define ASR_MODE_CONT 2'h2
`define ASR_MODE_STOP 2'h3

// phase lengths in machine cycles
`define ASR_SMP_SHORT 13'h0040
`define ASR_SMP_LONG 13'h1000
`define ASR_CMP_SHORT 13'h00B0
`define ASR_CMP_LONG 13'h0160

`define ASR_RESET_BYTE 8'h00

`endif

/* src/asr_phase_timer.v */
// down counter that times one sampling or compare phase
`timescale 1ns/1ns
`default_nettype none
module asr_phase_timer (
	input wire clk,
	input wire rst,
	input wire load,
	input wire abort,
	input wire [12:0] load_val,
	output reg expired
);
	reg [12:0] cnt_reg;
	reg running_reg;

	// expired pulses at the edge that ends the phase; phase lasts load_val cycles
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 13'h0000;
			running_reg <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (abort) begin
				running_reg <= 1'b0;
			end else if (load) begin
				cnt_reg <= load_val - 13'h0001;
				running_reg <= 1'b1;
			end else if (running_reg) begin
				if (cnt_reg == 13'h0001) begin
					expired <= 1'b1;
					running_reg <= 1'b0;
				end else begin
					cnt_reg <= cnt_reg - 13'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* src/asr_seq.v */
// converter sequencer: APB registers, channel sequencing, phase timing, result transfer
`timescale 1ns/1ns
`default_nettype none
`include "asr_consts.vh"
module asr_seq (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ext_trig_n,
	input wire timer_trig,
	input wire xfer_service_en,
	input wire xfer_ack,
	input wire [9:0] core_result,
	output reg [2:0] core_channel,
	output reg core_sample,
	output reg core_compare,
	output reg core_res_8bit,
	output reg xfer_req,
	output reg conv_irq,
	output reg irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_SAMPLE = 3'h1;
	localparam ST_COMPARE = 3'h2;
	localparam ST_HOLD = 3'h3;
	localparam ST_PAUSE = 3'h4;

	reg [2:0] state_reg;
	reg [1:0] mode_reg;
	reg [2:0] first_reg;
	reg [2:0] end_reg;
	reg [2:0] chan_reg;
	reg busy_reg;
	reg done_reg;
	reg irq_en_reg;
	reg hold_reg;
	reg [1:0] trig_reg;
	reg res_sel_reg;
	reg [1:0] smp_code_reg;
	reg [1:0] cmp_code_reg;
	reg [7:0] result_lo_reg;
	reg [1:0] result_hi_reg;
	reg [`ASR_IRQ_W-1:0] irq_status_reg;
	reg [`ASR_IRQ_W-1:0] irq_mask_reg;
	reg ext_prev_reg;

	wire [5:0] idx;
	wire acc;
	wire wr;
	wire mapped;
	wire ext_fall;
	wire activation;
	wire force_stop;
	wire load_sample;
	wire load_compare;
	wire smp_done;
	wire cmp_done;
	wire store;
	wire [9:0] conv_value;
	wire at_end;
	wire [2:0] after_chan;
	wire [`ASR_IRQ_W-1:0] irq_events;

	// next channel, wrapping 7 to 0
	function [2:0] next_chan;
		input [2:0] c;
		begin
			next_chan = c + 3'h1;
		end
	endfunction

	// phase length from one bit of a two-bit code
	function [12:0] phase_len;
		input code_bit;
		input [12:0] short_len;
		input [12:0] long_len;
		begin
			phase_len = code_bit ? long_len : short_len;
		end
	endfunction

	assign idx = paddr[7:2];
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite & ~pslverr;
	assign mapped = (idx == `ASR_IDX_SEQ_CFG) | (idx == `ASR_IDX_CTRL) |
		(idx == `ASR_IDX_RESULT_LO) | (idx == `ASR_IDX_RESULT_HI) |
		(idx == `ASR_IDX_IRQ_STATUS) | (idx == `ASR_IDX_IRQ_MASK);

	// software kick, pin falling edge (trig bit 0), timer (trig bit 1); the kick or any enabled trigger activates, none has priority
	assign ext_fall = ext_prev_reg & ~ext_trig_n;
	assign activation = (wr & (idx == `ASR_IDX_CTRL) & pwdata[`ASR_CTRL_KICK]) |
		(trig_reg[0] & ext_fall) | (trig_reg[1] & timer_trig);

	assign force_stop = wr & (idx == `ASR_IDX_CTRL) & ~pwdata[`ASR_CTRL_BUSY] & busy_reg;

	// the sequence walk only pauses in stop mode or finishes in single mode
	function seq_halts;
		input [1:0] mode;
		input last;
		begin
			seq_halts = (mode == `ASR_MODE_STOP) | (last & (mode != `ASR_MODE_CONT));
		end
	endfunction

	assign load_sample = ~force_stop & (((state_reg == ST_IDLE) & activation) |
		((state_reg == ST_PAUSE) & activation) | (store & ~seq_halts(mode_reg, at_end)));
	assign load_compare = ~force_stop & (state_reg == ST_SAMPLE) & smp_done;

	// result may be stored once the previous transfer has been taken
	assign store = ~force_stop & (((state_reg == ST_COMPARE) & cmp_done &
		~(xfer_service_en & xfer_req & ~xfer_ack)) |
		((state_reg == ST_HOLD) & (~xfer_req | xfer_ack)));

	assign conv_value = res_sel_reg ? {2'h0, core_result[7:0]} : core_result;
	assign at_end = (chan_reg == end_reg);
	assign after_chan = at_end ? first_reg : next_chan(chan_reg);

	assign irq_events[`ASR_IRQ_DONE] = store;
	assign irq_events[`ASR_IRQ_SEQ_END] = store & at_end;
	assign irq_events[`ASR_IRQ_HOLD] = (state_reg == ST_COMPARE) & cmp_done & ~store &
		~force_stop;

	asr_phase_timer u_smp_timer (
		.clk(clk),
		.rst(rst),
		.load(load_sample),
		.abort(force_stop),
		.load_val(phase_len(smp_code_reg[1], `ASR_SMP_SHORT, `ASR_SMP_LONG)),
		.expired(smp_done)
	);

	asr_phase_timer u_cmp_timer (
		.clk(clk),
		.rst(rst),
		.load(load_compare),
		.abort(force_stop),
		.load_val(phase_len(cmp_code_reg[0], `ASR_CMP_SHORT, `ASR_CMP_LONG)),
		.expired(cmp_done)
	);

	// sequencer state machine
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			chan_reg <= 3'h0;
			busy_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else if (force_stop) begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (activation) begin
						busy_reg <= 1'b1;
						chan_reg <= first_reg;
						state_reg <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (smp_done) begin
						state_reg <= ST_COMPARE;
					end
				end
				ST_COMPARE, ST_HOLD: begin
					if (store) begin
						hold_reg <= 1'b0;
						chan_reg <= after_chan;
						if (mode_reg == `ASR_MODE_STOP) begin
							state_reg <= ST_PAUSE;
						end else if (at_end & (mode_reg != `ASR_MODE_CONT)) begin
							state_reg <= ST_IDLE;
							busy_reg <= 1'b0;
						end else begin
							state_reg <= ST_SAMPLE;
						end
					end else if (cmp_done) begin
						state_reg <= ST_HOLD;
						hold_reg <= 1'b1;
					end
				end
				ST_PAUSE: begin
					if (activation) begin
						state_reg <= ST_SAMPLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// configuration and flags written by software
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= 2'h0;
			first_reg <= 3'h0;
			end_reg <= 3'h0;
			irq_en_reg <= 1'b0;
			trig_reg <= 2'h0;
			res_sel_reg <= 1'b0;
			smp_code_reg <= 2'h0;
			cmp_code_reg <= 2'h1;
			irq_mask_reg <= {`ASR_IRQ_W{1'b0}};
			ext_prev_reg <= 1'b1;
		end else begin
			ext_prev_reg <= ext_trig_n;
			if (wr & (idx == `ASR_IDX_SEQ_CFG)) begin
				mode_reg <= pwdata[`ASR_CFG_MODE_HI:`ASR_CFG_MODE_LO];
				first_reg <= pwdata[`ASR_CFG_FIRST_HI:`ASR_CFG_FIRST_LO];
				end_reg <= pwdata[`ASR_CFG_END_HI:`ASR_CFG_END_LO];
			end
			if (wr & (idx == `ASR_IDX_CTRL)) begin
				irq_en_reg <= pwdata[`ASR_CTRL_IRQ_EN];
				trig_reg <= pwdata[`ASR_CTRL_TRIG_HI:`ASR_CTRL_TRIG_LO];
			end
			if (wr & (idx == `ASR_IDX_RESULT_HI)) begin
				res_sel_reg <= pwdata[`ASR_HI_RES_SEL];
				smp_code_reg <= pwdata[`ASR_HI_SMP_HI:`ASR_HI_SMP_LO];
				cmp_code_reg <= pwdata[`ASR_HI_CMP_HI:`ASR_HI_CMP_LO];
			end
			if (wr & (idx == `ASR_IDX_IRQ_MASK)) begin
				irq_mask_reg <= pwdata[`ASR_IRQ_W-1:0];
			end
		end
	end

	// results, done flag, transfer request, interrupt status
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			result_lo_reg <= 8'h00;
			result_hi_reg <= 2'h0;
			done_reg <= 1'b0;
			xfer_req <= 1'b0;
			irq_status_reg <= {`ASR_IRQ_W{1'b0}};
		end else begin
			if (store) begin
				result_lo_reg <= conv_value[7:0];
				result_hi_reg <= conv_value[9:8];
			end
			// set wins over a clear by write or transfer acknowledge
			if (store) begin
				done_reg <= 1'b1;
			end else if (xfer_ack |
				(wr & (idx == `ASR_IDX_CTRL) & ~pwdata[`ASR_CTRL_DONE])) begin
				done_reg <= 1'b0;
			end
			if (store & irq_en_reg & xfer_service_en) begin
				xfer_req <= 1'b1;
			end else if (xfer_ack) begin
				xfer_req <= 1'b0;
			end
			irq_status_reg <= irq_events | (irq_status_reg &
				~((wr & (idx == `ASR_IDX_IRQ_STATUS)) ?
				pwdata[`ASR_IRQ_W-1:0] : {`ASR_IRQ_W{1'b0}}));
		end
	end

	// outputs toward the analog core and the interrupt controller
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			core_channel <= 3'h0;
			core_sample <= 1'b0;
			core_compare <= 1'b0;
			core_res_8bit <= 1'b0;
			conv_irq <= 1'b0;
			irq <= 1'b0;
		end else begin
			core_channel <= chan_reg;
			core_sample <= (state_reg == ST_SAMPLE);
			core_compare <= (state_reg == ST_COMPARE);
			core_res_8bit <= res_sel_reg;
			conv_irq <= done_reg & irq_en_reg;
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// APB slave: one wait state, answer in the second access cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= 32'h00000000;
			if (psel & penable & ~pready & ~pwrite) begin
				case (idx)
					`ASR_IDX_SEQ_CFG: begin
						prdata[7:0] <= {mode_reg, (busy_reg ? chan_reg : first_reg), end_reg};
					end
					`ASR_IDX_CTRL: begin
						prdata[7:0] <= {busy_reg, done_reg, irq_en_reg, hold_reg,
							trig_reg, 2'h0};
					end
					`ASR_IDX_RESULT_LO: begin
						prdata[7:0] <= result_lo_reg;
					end
					`ASR_IDX_RESULT_HI: begin
						prdata[7:0] <= {6'h00, result_hi_reg};
					end
					`ASR_IDX_IRQ_STATUS: begin
						prdata[`ASR_IRQ_W-1:0] <= irq_status_reg;
					end
					`ASR_IDX_IRQ_MASK: begin
						prdata[`ASR_IRQ_W-1:0] <= irq_mask_reg;
					end
					default: begin
						prdata <= 32'h00000000;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* verif/asr_seq_properties.sv */
// port-level checks of the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module asr_seq_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic xfer_ack,
	input wire logic [2:0] core_channel,
	input wire logic core_sample,
	input wire logic core_compare,
	input wire logic xfer_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [12:0] scnt_reg;
	logic [12:0] ccnt_reg;
	// phase lengths in cycles
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			scnt_reg <= 13'h0000;
			ccnt_reg <= 13'h0000;
		end else begin
			scnt_reg <= core_sample ? scnt_reg + 13'h0001 : 13'h0000;
			ccnt_reg <= core_compare ? ccnt_reg + 13'h0001 : 13'h0000;
		end
	end
	a_ready_single: assert property (pready |=> !pready) else $error("pready held");
	a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not 0");
	a_sample_len: assert property ($fell(core_sample) && core_compare |->
		scnt_reg == 13'h0040 || scnt_reg == 13'h1000) else $error("sampling length");
	a_compare_len: assert property ($fell(core_compare) |->
		ccnt_reg == 13'h00B0 || ccnt_reg == 13'h0160) else $error("compare length");
	a_phase_order: assert property ($rose(core_compare) |-> $past(core_sample))
		else $error("compare without sampling");
	a_phase_excl: assert property (!(core_sample && core_compare))
		else $error("phases overlap");
	a_chan_stable: assert property (core_compare |-> $stable(core_channel))
		else $error("channel moved");
	a_req_held: assert property (xfer_req && !xfer_ack |=> xfer_req)
		else $error("request dropped");
endmodule
bind asr_seq asr_seq_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer_ack(xfer_ack),
	.core_channel(core_channel), .core_sample(core_sample), .core_compare(core_compare),
	.xfer_req(xfer_req));
`default_nettype wire

/* verif/asr_far_model.sv */
// far side: compare core result source and transfer service
`timescale 1ns/1ns
`default_nettype none
module asr_far_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] core_channel,
	input wire logic core_compare,
	input wire logic xfer_req,
	input wire logic [9:0] ack_delay,
	output logic [9:0] core_result,
	output logic xfer_ack,
	output logic [7:0] n_xfer,
	output logic [7:0] n_cmp
);
	logic [2:0] log [0:255];
	logic [2:0] ch_reg;
	logic [9:0] wait_reg;
	logic cmp_d;
	// value tied to channel
	assign core_result = {core_channel, 4'h9, ~core_channel};
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			xfer_ack <= 1'h0;
			n_xfer <= 8'h00;
			n_cmp <= 8'h00;
			wait_reg <= 10'h000;
			cmp_d <= 1'h0;
			ch_reg <= 3'h0;
		end else begin
			cmp_d <= core_compare;
			xfer_ack <= 1'h0;
			wait_reg <= xfer_req ? wait_reg + 10'h001 : 10'h000;
			if (core_compare) begin
				ch_reg <= core_channel;
			end
			if (cmp_d && !core_compare) begin
				log[n_cmp] <= ch_reg;
				n_cmp <= n_cmp + 8'h01;
			end
			if (xfer_req && !xfer_ack && wait_reg >= ack_delay) begin
				xfer_ack <= 1'h1;
				wait_reg <= 10'h000;
				n_xfer <= n_xfer + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/asr_seq_bench.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module asr_seq_bench;
	logic clk, rst, psel, penable, pwrite, ext_trig_n, timer_trig, slv, pready, pslverr;
	logic [7:0] paddr, n_xfer, n_cmp;
	logic [31:0] pwdata, prdata, q;
	logic [9:0] core_result, ack_delay, r;
	logic [2:0] core_channel;
	logic core_sample, core_compare, core_res_8bit, xfer_req, xfer_ack, conv_irq, irq;
	logic svc;
	int s_cnt = 0, c_cnt = 0, s_len = 0, c_len = 0;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	int b, bx;
	asr_seq DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_trig_n(ext_trig_n), .timer_trig(timer_trig), .xfer_service_en(svc),
		.xfer_ack(xfer_ack), .core_result(core_result), .core_channel(core_channel),
		.core_sample(core_sample), .core_compare(core_compare), .core_res_8bit(core_res_8bit),
		.xfer_req(xfer_req), .conv_irq(conv_irq), .irq(irq));
	asr_far_model u_far (.clk(clk), .rst(rst), .core_channel(core_channel),
		.core_compare(core_compare), .xfer_req(xfer_req), .ack_delay(ack_delay),
		.core_result(core_result), .xfer_ack(xfer_ack), .n_xfer(n_xfer), .n_cmp(n_cmp));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares = miscompares + 1;
			give_verdict;
		end
	end
	// last finished sampling and compare lengths seen at the core pins
	always @(posedge clk) begin
		s_cnt <= core_sample ? s_cnt + 1 : 0;
		c_cnt <= core_compare ? c_cnt + 1 : 0;
		if (!core_sample && s_cnt != 0) begin
			s_len <= s_cnt;
		end
		if (!core_compare && c_cnt != 0) begin
			c_len <= c_cnt;
		end
	end
	task give_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked = checked + 1;
		if (s !== e) begin
			miscompares = miscompares + 1;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		q = prdata;
		slv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 8'h00);
		chk(q, e);
	endtask
	task wait_idle;
		int k;
		k = 0;
		do begin
			apb(1'h0, 8'hD4, 8'h00);
			k = k + 1;
		end while (q[7] !== 1'h0 && k < 3000);
		chk(q[7], 1'h0);
	endtask
	task res_chk(input logic [2:0] c, input logic eight);
		r = {c, 4'h9, ~c};
		rd(8'hD8, {24'h000000, r[7:0]});
		rd(8'hDC, eight ? 32'h0 : {30'h0, r[9:8]});
	endtask
	task pulse(input logic tmr);
		timer_trig <= tmr;
		ext_trig_n <= tmr;
		@(posedge clk);
		timer_trig <= 1'h0;
		ext_trig_n <= 1'h1;
		repeat (300) @(posedge clk);
	endtask
	initial begin
		rst = 1'h1;
		{psel, penable, pwrite, timer_trig} = 4'h0;
		ext_trig_n = 1'h1;
		paddr = 8'h00;
		pwdata = 32'h0;
		ack_delay = 10'h005;
		svc = 1'h1;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(8'hDC, 32'h0);
		rd(8'h00, 32'h0);
		chk(slv, 1'h1);
		apb(1'h1, 8'hDC, 8'h00);
		b = n_cmp;
		bx = n_xfer;
		apb(1'h1, 8'hD0, 8'h31);
		apb(1'h1, 8'hD4, 8'h22);
		wait_idle;
		repeat (20) @(posedge clk);
		chk(n_xfer - bx, 4);
		chk(s_len, 64);
		chk(c_len, 176);
		for (int i = 0; i < 4; i++) begin
			chk(u_far.log[b + i], (i + 6) % 8);
		end
		res_chk(3'h1, 1'h0);
		apb(1'h1, 8'hDC, 8'hE8);
		apb(1'h1, 8'hD0, 8'h12);
		apb(1'h1, 8'hD4, 8'h22);
		wait_idle;
		chk(core_res_8bit, 1'h1);
		res_chk(3'h2, 1'h1);
		chk(s_len, 4096);
		chk(c_len, 352);
		apb(1'h1, 8'hDC, 8'h00);
		ack_delay <= 10'h3FF;
		apb(1'h1, 8'hE0, 8'h07);
		bx = n_xfer;
		apb(1'h1, 8'hD0, 8'h01);
		apb(1'h1, 8'hD4, 8'h22);
		wait_idle;
		rd(8'hE0, 32'h7);
		repeat (1100) @(posedge clk);
		chk(n_xfer - bx, 2);
		res_chk(3'h1, 1'h0);
		for (int m = 0; m < 4; m++) begin
			apb(1'h1, m[1] ? 8'hE0 : 8'hE4, m[0] ? 8'h00 : 8'h04);
			repeat (2) @(posedge clk);
			chk(irq, m == 0);
		end
		ack_delay <= 10'h005;
		svc <= 1'h0;
		b = n_cmp;
		apb(1'h1, 8'hD0, 8'h9B);
		apb(1'h1, 8'hD4, 8'h22);
		while (n_cmp - b < 3) @(posedge clk);
		wait (core_sample === 1'h1);
		chk(conv_irq, 1'h1);
		chk(xfer_req, 1'h0);
		apb(1'h1, 8'hD4, 8'h00);
		repeat (400) @(posedge clk);
		chk(n_cmp - b, 3);
		rd(8'hD4, 32'h0);
		res_chk(3'h3, 1'h0);
		chk(conv_irq, 1'h0);
		svc <= 1'h1;
		for (int t = 1; t < 4; t++) begin
			b = n_cmp;
			apb(1'h1, 8'hD0, 8'hE5);
			apb(1'h1, 8'hD4, {4'h2, t[1:0], 2'h2});
			repeat (300) @(posedge clk);
			pulse(1'h1);
			pulse(1'h0);
			chk(n_cmp - b, 1 + t[1] + t[0]);
			chk(u_far.log[n_cmp - 1], t == 3 ? 4 : 5);
			apb(1'h1, 8'hD4, 8'h00);
		end
		give_verdict;
	end
endmodule
`default_nettype wire
